// File: hdl/plc_fec_encoder.sv
// Purpose: Reed-Solomon and convolutional encoder chain for the modem transmit path.
// Assumes: Input bytes arrive one per cycle at most with valid/ready; the mapper
//          always accepts coded bits (no stall on the output side).
// Notes:   A frame is one codeword of K bytes in RS modes; in CC-only mode a frame
//          ends with i_last. Bits leave MSB first.
`timescale 1ns/1ps

module plc_fec_encoder
    import fec_pkg::*;
(
    input  wire logic       i_sys_clk,   // Core clock, 10 MHz.
    input  wire logic       i_sys_rst,   // Asynchronous reset, active high.
    input  wire logic [1:0] i_mode,      // fec_mode_t, sampled at frame start.
    input  wire logic       i_short_rs,  // 1 selects 247 message bytes, else 239.
    input  wire logic       i_byte_vld,  // Payload byte valid.
    input  wire logic [7:0] i_byte,      // Payload byte.
    input  wire logic       i_last,      // Last byte of frame (CC-only mode).
    output logic            o_byte_rdy,  // Encoder accepts a byte.
    output logic            o_rs_vld,    // RS symbol out (RS-only mode).
    output logic [7:0]      o_rs_sym,    // RS codeword symbol.
    output logic            o_cc_vld,    // Coded pair valid.
    output logic [1:0]      o_cc_pair,   // Coded pair.
    output logic            o_frame_end  // Pulse with last output of frame.
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MSG,
        ST_PAR,
        ST_FLUSH
    } phase_t;

    typedef struct packed {
        phase_t         phase;
        fec_mode_t      mode;
        logic [7:0]     npar;
        logic [7:0]     cnt;
        logic [127:0]   par;     // Up to 16 parity bytes, index 0 oldest.
        logic [7:0]     sr;      // Byte being serialised.
        logic [3:0]     bitn;    // Bits left in sr.
        logic           last;    // Current byte closes the frame.
        logic           rdy;
        logic           rs_vld;
        logic [7:0]     rs_sym;
        logic           fend;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    logic       cc_clear;
    logic       cc_in_vld;
    logic       cc_in_bit;
    logic       cc_vld;
    logic [1:0] cc_pair;
    logic [7:0] fb;
    logic [7:0] mlen;
    logic [127:0] par_base;  // Remainder seen by an incoming byte.

    // =====================================================================
    // Field arithmetic
    // =====================================================================
    // Multiply in GF(256); reused for every generator tap.
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[7] ? ((x << 1) ^ RS_FIELD_POLY[7:0]) : (x << 1);
        end
        return p;
    endfunction : gf_mul

    // Generator coefficient j of prod (x - alpha^i), i = 0..n-1, built at elaboration.
    function automatic logic [7:0] gen_coef(input int n, input int j);
        logic [7:0] g [0:16];
        logic [7:0] r;
        r = 8'h01;
        for (int k = 0; k <= 16; k++) begin
            g[k] = 8'h00;
        end
        g[0] = 8'h01;
        for (int i = 0; i < n; i++) begin
            for (int k = 16; k > 0; k--) begin
                g[k] = g[k - 1] ^ gf_mul(g[k], r);
            end
            g[0] = gf_mul(g[0], r);
            r = gf_mul(r, RS_ALPHA);
        end
        return g[j];
    endfunction : gen_coef

    // Coefficient tables for both parity lengths; index 0 is the x^0 term.
    localparam int unsigned PL = RS_PAR_LONG;
    localparam int unsigned PS = RS_PAR_SHORT;
    logic [7:0] coef_l [0:15];
    logic [7:0] coef_s [0:15];
    always_comb begin
        for (int j = 0; j < 16; j++) begin
            coef_l[j] = gen_coef(PL, j);
            coef_s[j] = (j < PS) ? gen_coef(PS, j) : 8'h00;
        end
    end

    // =====================================================================
    // Sequencer: message bytes, parity bytes, bit serialisation.
    // =====================================================================
    // A byte is taken only when the serialiser is empty or emptying, so one
    // byte yields eight coded pairs and input stalls for eight cycles in
    // convolutional modes; RS-only runs at full byte rate.
    always_comb begin
        st_next        = st_reg;
        st_next.rs_vld = 1'b0;
        st_next.fend   = 1'b0;
        cc_clear       = 1'b0;
        cc_in_vld      = 1'b0;
        cc_in_bit      = st_reg.sr[7];
        fb             = 8'h00;
        mlen           = (st_reg.npar == 8'(RS_PAR_SHORT)) ? 8'(RS_K_SHORT) : 8'(RS_K_LONG);
        // The first byte of a frame must divide from an empty remainder, so a
        // remainder left over from an aborted frame can never leak into parity.
        par_base       = (st_reg.phase == ST_IDLE) ? 128'h0 : st_reg.par;

        // Serialiser drains MSB first into the convolutional encoder.
        if (st_reg.bitn != 4'h0) begin
            cc_in_vld    = 1'b1;
            st_next.sr   = {st_reg.sr[6:0], 1'b0};
            st_next.bitn = st_reg.bitn - 4'h1;
            if (st_reg.bitn == 4'h1 && st_reg.last) begin
                st_next.fend = 1'b1;
                st_next.last = 1'b0;
                st_next.phase = ST_IDLE;
            end
        end

        unique case (st_reg.phase)
            ST_IDLE: begin
                if (st_reg.bitn <= 4'h1) begin
                    st_next.rdy = 1'b1;
                end
                if (i_byte_vld && st_reg.rdy) begin
                    st_next.mode = fec_mode_t'(i_mode);
                    st_next.npar = i_short_rs ? 8'(RS_PAR_SHORT) : 8'(RS_PAR_LONG);
                    st_next.par  = '0;
                    st_next.cnt  = 8'h00;
                    cc_clear     = 1'b1;
                    st_next.phase = ST_MSG;
                end
            end
            ST_MSG: begin
                st_next.rdy = (st_reg.mode == MODE_RS_ONLY) || (st_reg.bitn <= 4'h1);
            end
            ST_PAR: begin
                if (st_reg.mode == MODE_RS_ONLY || st_reg.bitn <= 4'h1) begin
                    if (st_reg.mode == MODE_RS_ONLY) begin
                        st_next.rs_vld = 1'b1;
                        st_next.rs_sym = st_reg.par[127:120];
                    end else begin
                        st_next.sr   = st_reg.par[127:120];
                        st_next.bitn = 4'h8;
                    end
                    st_next.par = {st_reg.par[119:0], 8'h00};
                    st_next.cnt = st_reg.cnt + 8'h01;
                    if (st_reg.cnt + 8'h01 == st_reg.npar) begin
                        if (st_reg.mode == MODE_RS_ONLY) begin
                            st_next.fend  = 1'b1;
                            st_next.phase = ST_IDLE;
                        end else begin
                            st_next.last  = 1'b1;
                            st_next.phase = ST_FLUSH;
                        end
                    end
                end
            end
            ST_FLUSH: begin
                st_next.rdy = 1'b0;
            end
        endcase

        // Byte acceptance in message phase (first byte taken in idle too).
        if (i_byte_vld && st_reg.rdy &&
            (st_reg.phase == ST_IDLE || st_reg.phase == ST_MSG)) begin
            if (st_reg.phase == ST_IDLE) begin
                st_next.cnt = 8'h01;
            end else begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
            if (fec_mode_t'(st_reg.phase == ST_IDLE ? i_mode : st_reg.mode) != MODE_CC_ONLY) begin
                // Systematic LFSR division by the generator polynomial.
                fb = i_byte ^ par_base[127:120];
                for (int j = 0; j < 16; j++) begin
                    if (st_next.npar == 8'(RS_PAR_LONG)) begin
                        st_next.par[127 - 8*j -: 8] = ((j < 15) ? par_base[119 - 8*j -: 8]
                            : 8'h00) ^ gf_mul(fb, coef_l[15 - j]);
                    end else if (j < 8) begin
                        st_next.par[127 - 8*j -: 8] = ((j < 7) ? par_base[119 - 8*j -: 8]
                            : 8'h00) ^ gf_mul(fb, coef_s[7 - j]);
                    end
                end
            end
            if (fec_mode_t'(st_reg.phase == ST_IDLE ? i_mode : st_reg.mode) == MODE_RS_ONLY) begin
                st_next.rs_vld = 1'b1;
                st_next.rs_sym = i_byte;
            end else begin
                st_next.sr   = i_byte;
                st_next.bitn = 4'h8;
            end
            st_next.rdy = (fec_mode_t'(st_reg.phase == ST_IDLE ? i_mode : st_reg.mode)
                           == MODE_RS_ONLY);
            // Codeword boundary or CC-only frame end.
            if (fec_mode_t'(st_reg.phase == ST_IDLE ? i_mode : st_reg.mode) == MODE_CC_ONLY) begin
                if (i_last) begin
                    st_next.last  = 1'b1;
                    st_next.rdy   = 1'b0;
                    st_next.phase = ST_FLUSH;
                end
            end else if (st_next.cnt == (st_reg.phase == ST_IDLE ?
                         (i_short_rs ? 8'(RS_K_SHORT) : 8'(RS_K_LONG)) : mlen)) begin
                st_next.cnt   = 8'h00;
                st_next.rdy   = 1'b0;
                st_next.phase = ST_PAR;
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '{phase: ST_IDLE, mode: MODE_RS_ONLY, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Inner code on the serialised stream.
    conv_enc u_conv (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_clear    (cc_clear),
        .i_bit_vld  (cc_in_vld),
        .i_bit      (cc_in_bit),
        .o_pair_vld (cc_vld),
        .o_pair     (cc_pair)
    );

    assign o_byte_rdy  = st_reg.rdy;
    assign o_rs_vld    = st_reg.rs_vld;
    assign o_rs_sym    = st_reg.rs_sym;
    assign o_cc_vld    = cc_vld;
    assign o_cc_pair   = cc_pair;
    assign o_frame_end = st_reg.fend;
endmodule : plc_fec_encoder

// File: hdl/fec_pkg.sv
// Purpose: Shared constants and types for the forward error correction encoder.
// Assumes: One core clock; byte-wide payload from the framing side.
// Notes:   The field polynomial and first root are plain choices, not fixed by the code length.
package fec_pkg;
    // =====================================================================
    // Reed-Solomon geometry
    // =====================================================================
    localparam int unsigned RS_N          = 255;  // Symbols per codeword.
    localparam int unsigned RS_K_LONG     = 239;  // Message symbols, strong mode.
    localparam int unsigned RS_K_SHORT    = 247;  // Message symbols, light mode.
    localparam int unsigned RS_PAR_LONG   = RS_N - RS_K_LONG;   // 16 parity symbols.
    localparam int unsigned RS_PAR_SHORT  = RS_N - RS_K_SHORT;  // 8 parity symbols.
    localparam logic [8:0]  RS_FIELD_POLY = 9'h11D;  // Generator of GF(256).
    localparam logic [7:0]  RS_ALPHA      = 8'h02;   // Primitive element.

    // =====================================================================
    // Convolutional code
    // =====================================================================
    localparam int unsigned CC_K     = 7;        // Register span including current bit.
    localparam logic [6:0]  CC_G0    = 7'h5B;    // Octal 133.
    localparam logic [6:0]  CC_G1    = 7'h79;    // Octal 171.
    localparam logic [5:0]  CC_RESET = 6'h00;    // Register state at each frame start.

    // Operating modes of the encoder chain.
    typedef enum logic [1:0] {
        MODE_RS_ONLY,
        MODE_CC_ONLY,
        MODE_CONCAT
    } fec_mode_t;
endpackage : fec_pkg

// File: hdl/conv_enc.sv
// Purpose: Rate-half convolutional encoder, one input bit to two output bits.
// Assumes: Caller clears the register at frame start.
// Notes:   Output pair is registered; one bit accepted per enabled cycle.
`timescale 1ns/1ps
module conv_enc
    import fec_pkg::*;
(
    input  wire logic i_sys_clk,   // Core clock.
    input  wire logic i_sys_rst,   // Asynchronous reset, active high.
    input  wire logic i_clear,     // Return register to the all-zero state.
    input  wire logic i_bit_vld,   // Input bit is present.
    input  wire logic i_bit,       // Input bit.
    output logic      o_pair_vld,  // Output pair is present.
    output logic [1:0] o_pair      // Bit 1 from 133, bit 0 from 171.
);
    typedef struct packed {
        logic [5:0] hist;
        logic       vld;
        logic [1:0] pair;
    } cc_state_t;

    cc_state_t st_reg;
    cc_state_t st_next;
    logic [6:0] win;

    // =====================================================================
    // Tap sums over the seven-bit window.
    // =====================================================================
    always_comb begin
        st_next = st_reg;
        win     = {i_bit, st_reg.hist};
        st_next.vld = i_bit_vld;
        if (i_bit_vld) begin
            st_next.pair = {^(win & CC_G0), ^(win & CC_G1)};
            st_next.hist = win[6:1];
        end
        if (i_clear) begin
            st_next.hist = CC_RESET;
        end
    end

    // Register the whole state.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_pair_vld = st_reg.vld;
    assign o_pair     = st_reg.pair;
endmodule : conv_enc

// File: testbench/plc_fec_encoder_properties.sv
// Purpose: Port assertions for the encoder chain.
// Assumes: Mode is held steady through each frame.
// Notes:   Parity values are judged by the bench, not here.
`timescale 1ns/1ps
module plc_fec_encoder_checker
    import fec_pkg::*;
(
    input wire logic       i_sys_clk,   // Core clock.
    input wire logic       i_sys_rst,   // Asynchronous reset, active high.
    input wire logic [1:0] i_mode,      // Frame mode.
    input wire logic       i_byte_vld,  // Byte offered.
    input wire logic [7:0] i_byte,      // Byte value.
    input wire logic       o_byte_rdy,  // Byte accepted.
    input wire logic       o_rs_vld,    // Symbol out.
    input wire logic [7:0] o_rs_sym,    // Symbol value.
    input wire logic       o_cc_vld,    // Coded pair out.
    input wire logic       o_frame_end  // End of frame.
);
    // =====================================================================
    // Helpers
    // =====================================================================
    logic       taken;        // Byte accepted this cycle.
    logic [7:0] sym_cnt_reg;  // Symbols already issued in this frame.
    assign taken = i_byte_vld & o_byte_rdy;
    // A symbol count lets one assertion pin the codeword length exactly.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sym_cnt_reg <= 8'h00;
        end else if (o_frame_end) begin
            sym_cnt_reg <= 8'h00;
        end else if (o_rs_vld) begin
            sym_cnt_reg <= sym_cnt_reg + 8'h01;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // =====================================================================
    // Assertions
    // =====================================================================
    AST_RS_ECHO: assert property (taken && i_mode == 2'h0 |=> o_rs_vld && o_rs_sym == $past(i_byte))
        else $error("message byte not echoed next cycle");
    AST_RS_LEN: assert property (o_frame_end && o_rs_vld |-> sym_cnt_reg == 8'hFE)
        else $error("codeword length is not 255");
    AST_PAR_NO_RDY: assert property (o_rs_vld && sym_cnt_reg inside {[8'hF7:8'hFC]} |-> !o_byte_rdy)
        else $error("byte accepted during parity");
    AST_CC_BURST: assert property (taken && i_mode != 2'h0 |-> ##2 o_cc_vld [*8])
        else $error("byte did not give eight pairs");
    AST_CC_HOLD: assert property (taken && i_mode != 2'h0 |=> !o_byte_rdy [*6])
        else $error("byte accepted while serialising");
    AST_CC_RUN: assert property ($rose(o_cc_vld) |-> o_cc_vld [*8])
        else $error("pair run shorter than a byte");
    AST_ONE_PATH: assert property (!(o_rs_vld && o_cc_vld))
        else $error("both outputs active together");
    AST_END_PULSE: assert property (o_frame_end |=> !o_frame_end)
        else $error("frame end longer than one cycle");
    // Main scenarios reached.
    COV_RS: cover property (taken && i_mode == 2'h0);
    COV_CAT: cover property (taken && i_mode == 2'h2);
    COV_END: cover property (o_frame_end);
endmodule : plc_fec_encoder_checker

bind plc_fec_encoder plc_fec_encoder_checker plc_fec_encoder_checker_i (.i_sys_clk, .i_sys_rst,
    .i_mode, .i_byte_vld, .i_byte, .o_byte_rdy, .o_rs_vld, .o_rs_sym, .o_cc_vld, .o_frame_end);

// File: testbench/mac_frame_src.sv
// Purpose: Framing-side byte source with a valid/ready handshake.
// Assumes: Driven on the falling edge; a byte is taken at a rising edge with ready.
// Notes:   A released data bus shows the inverse of its last byte.
`timescale 1ns/1ps
module mac_frame_src (
    input  wire logic i_sys_clk,   // Core clock.
    input  wire logic i_byte_rdy,  // Encoder ready.
    output logic      o_byte_vld,  // Byte offered.
    output logic [7:0] o_byte,     // Byte value.
    output logic      o_last       // Last byte of frame.
);
    initial begin
        o_byte_vld = 1'b0;
        o_byte     = 8'h00;
        o_last     = 1'b0;
    end
    // Bytes follow b0 + 37 * index; the offer stands until it is taken.
    task send(input int n, input logic [7:0] b0, input logic use_last);
        for (int i = 0; i < n; i++) begin
            @(negedge i_sys_clk);
            o_byte_vld = 1'b1;
            o_byte     = 8'(b0 + i * 37);
            o_last     = use_last && (i == n - 1);
            while (!i_byte_rdy) @(negedge i_sys_clk);
            @(posedge i_sys_clk);
        end
        @(negedge i_sys_clk);
        o_byte_vld = 1'b0;
        o_byte     = ~o_byte;
        o_last     = 1'b0;
    endtask : send
endmodule : mac_frame_src

// File: testbench/plc_fec_encoder_tb.sv
// Purpose: Self-checking bench for the encoder chain.
// Assumes: Mode held for a whole frame; the mapper never stalls.
// Notes:   Parity bytes are recomputed from the generator roots and compared in full.
`timescale 1ns/1ps
module plc_fec_encoder_tb;
    import fec_pkg::*;
    logic       i_sys_clk, i_sys_rst, i_short_rs, i_byte_vld, i_last;
    logic       o_byte_rdy, o_rs_vld, o_cc_vld, o_frame_end;
    logic [1:0] i_mode, o_cc_pair;
    logic [7:0] i_byte, o_rs_sym;
    logic [7:0] rs_q[$], ref_q[$];
    logic [1:0] cc_q[$], exp_q[$];
    logic [5:0] st;
    int         n_errors, total_checks, fe_n;

    plc_fec_encoder plc_fec_encoder_i (.i_sys_clk, .i_sys_rst, .i_mode, .i_short_rs, .i_byte_vld,
        .i_byte, .i_last, .o_byte_rdy, .o_rs_vld, .o_rs_sym, .o_cc_vld, .o_cc_pair, .o_frame_end);
    mac_frame_src mac_frame_src_i (.i_sys_clk, .i_byte_rdy(o_byte_rdy), .o_byte_vld(i_byte_vld),
        .o_byte(i_byte), .o_last(i_last));

    // =====================================================================
    // Clock, observation and shared tasks
    // =====================================================================
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // Outputs are gathered at the falling edge, where they have settled.
    always @(negedge i_sys_clk) begin
        if (o_rs_vld) rs_q.push_back(o_rs_sym);
        if (o_cc_vld) cc_q.push_back(o_cc_pair);
        if (o_frame_end) fe_n++;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // Clearing on the rising edge keeps clear and capture apart.
    task start(input logic [1:0] m, input logic sh);
        @(posedge i_sys_clk);
        rs_q.delete(); cc_q.delete(); exp_q.delete(); ref_q.delete(); fe_n = 0;
        @(negedge i_sys_clk);
        i_mode = m; i_short_rs = sh;
    endtask : start
    task wait_end(input int k);
        for (int t = 0; t < 6000 && fe_n < k; t++) @(negedge i_sys_clk);
        repeat (4) @(negedge i_sys_clk);
        check(fe_n, k);
    endtask : wait_end
    // Frame bytes follow b0 + 37 * index, as the source sends them.
    task mk(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++) ref_q.push_back(8'(b0 + i * 37));
    endtask : mk
    // Field product for the reference, reduced by the package's field polynomial.
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ a;
            a = a[7] ? 8'((a << 1) ^ RS_FIELD_POLY) : 8'(a << 1);
        end
        return p;
    endfunction : gmul
    // Appends p parity bytes, highest degree first, for the k message bytes at the
    // head of ref_q: the remainder over the generator with roots alpha^0..alpha^(p-1).
    task automatic rs_ref(input int k, input int p);
        logic [7:0] g[0:16];
        logic [7:0] rem[0:15];
        logic [7:0] r;
        logic [7:0] f;
        r = 8'h01;
        for (int i = 0; i <= 16; i++) g[i] = (i == 0) ? 8'h01 : 8'h00;
        for (int i = 0; i < 16; i++) rem[i] = 8'h00;
        for (int i = 0; i < p; i++) begin
            for (int j = 16; j > 0; j--) g[j] = g[j - 1] ^ gmul(g[j], r);
            g[0] = gmul(g[0], r);
            r = gmul(r, RS_ALPHA);
        end
        for (int i = 0; i < k; i++) begin
            f = ref_q[i] ^ rem[p - 1];
            for (int j = p - 1; j > 0; j--) rem[j] = rem[j - 1] ^ gmul(f, g[j]);
            rem[0] = gmul(f, g[0]);
        end
        for (int j = p - 1; j >= 0; j--) ref_q.push_back(rem[j]);
    endtask : rs_ref
    // Reference encoder over ref_q[first +: n]: current bit sits above six stored bits.
    task enc(input int first, input int n);
        logic [7:0] b;
        logic [6:0] w;
        st = CC_RESET;
        for (int i = first; i < first + n; i++) begin
            b = ref_q[i];
            for (int j = 7; j >= 0; j--) begin
                w = {b[j], st};
                exp_q.push_back({^(w & CC_G0), ^(w & CC_G1)});
                st = w[6:1];
            end
        end
    endtask : enc
    task cmp_cc(input int n);
        for (int i = 0; i < n; i++) check(cc_q[i], exp_q[i]);
    endtask : cmp_cc

    // =====================================================================
    // Scenarios
    // =====================================================================
    task t_rs(input logic sh);
        int n;
        n = sh ? RS_K_SHORT : RS_K_LONG;
        start(2'h0, sh);
        mac_frame_src_i.send(n, 8'h11, 1'b0);
        wait_end(1);
        mk(n, 8'h11);
        rs_ref(n, RS_N - n);
        check(rs_q.size(), RS_N);
        for (int i = 0; i < RS_N; i++) check(rs_q[i], ref_q[i]);
        $display("test rs k=%0d done", n);
    endtask : t_rs
    task t_cc;
        start(2'h1, 1'b0);
        mac_frame_src_i.send(3, 8'hA5, 1'b1);
        wait_end(1);
        mk(3, 8'hA5);
        enc(0, 3);
        mac_frame_src_i.send(2, 8'h3C, 1'b1);
        wait_end(2);
        mk(2, 8'h3C);
        enc(3, 2);
        check(cc_q.size(), 40);
        cmp_cc(40);
        $display("test cc done");
    endtask : t_cc
    task t_cat;
        start(2'h2, 1'b1);
        mac_frame_src_i.send(RS_K_SHORT, 8'h5A, 1'b0);
        wait_end(1);
        mk(RS_K_SHORT, 8'h5A);
        rs_ref(RS_K_SHORT, RS_PAR_SHORT);
        enc(0, RS_N);
        check(cc_q.size(), RS_N * 8);
        cmp_cc(RS_N * 8);
        $display("test concat done");
    endtask : t_cat

    initial begin
        i_sys_rst = 1'b1; i_mode = 2'h0; i_short_rs = 1'b0;
        n_errors = 0; total_checks = 0; fe_n = 0;
        repeat (16) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        t_rs(1'b0);
        t_rs(1'b1);
        t_cc();
        t_cat();
        stop_test();
    end
    // Watchdog sized well beyond the roughly 3000 cycles the tests need.
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : plc_fec_encoder_tb
